// File: inc/eep_if.sv
`timescale 1ns/10ps
`default_nettype none
interface eep_if;
  logic scl;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  logic sda;
  // open drain: any enabled driver pulls low
  assign sda = ~((sda_m_oe & ~sda_m_o) | (sda_s_oe & ~sda_s_o));
  modport dev  (input scl, input sda, output sda_s_o, output sda_s_oe);
  modport host (output scl, input sda, output sda_m_o, output sda_m_oe);
endinterface
`default_nettype wire

// File: inc/eep_pkg.sv
package eep_pkg;
  localparam int unsigned MEM_DEPTH        = 256;
  localparam logic [7:0]  PROT_BASE        = 8'h80;
  localparam logic [7:0]  NODE48_BASE      = 8'hFA;
  localparam logic [7:0]  NODE64_BASE      = 8'hF8;
  localparam logic [3:0]  CTRL_CODE        = 4'b1010;
  localparam logic [15:0] ENCAP_FILL       = 16'hFFFE;
  localparam logic [15:0] RSVD_EXT         = 16'hFFFF;
  localparam int unsigned CLK_MHZ          = 250;
  localparam int unsigned PROG_TIME_US     = 3000;
  localparam int unsigned PROG_CYC         = PROG_TIME_US * CLK_MHZ;
  localparam int unsigned SCL_HALF_CYC     = 8;
  localparam logic [3:0]  BIT_LAST         = 4'h8;
  // organisation id is arbitrary, not a real assignment
  localparam logic [23:0] ORG_ID_DFLT      = 24'h12_3456;
  localparam logic [39:0] EXT_ID_DFLT      = 40'h01_0203_0405;

  function automatic logic [7:0] eep_inc(input logic [7:0] a);
    return 8'(a + 8'h01);
  endfunction
endpackage

// File: rtl/eep_dev.sv
// Functional notes
// - writes to 80h-FFh never change memory
// - lower half writable, all readable
// - no acknowledge while programming runs
// - programming starts at write stop
// - host polls with write control byte
// - nack busy, ack means done
// - direction bit one selects read
// - pointer holds last address plus one
// - ack control, send byte, nack stop
// - word address loaded before repeated start
// - host resends control with read bit
// - host ack gives next byte
// - pointer advances after every byte
// - low supply blocks programming
// - 48-bit id at FAh-FFh
// - 64-bit id at F8h-FFh
// - id lives in protected upper half
// - host inserts FFFEh for encapsulation
// - 64-bit extension avoids FFFEh/FFFFh
// - respond only to code 1010
// - release data after host nack
// - word address loads pointer
`timescale 1ns/10ps
`default_nettype none
module eep_dev #(
  parameter int unsigned PROG_CYC = eep_pkg::PROG_CYC,
  parameter bit          ID64     = 1'b0,
  parameter logic [23:0] ORG_ID   = eep_pkg::ORG_ID_DFLT,
  parameter logic [39:0] EXT_ID   = eep_pkg::EXT_ID_DFLT
) (
  input  wire logic i_mclk,
  input  wire logic i_rst_n,
  input  wire logic i_vdd_low,
  eep_if.dev        bus,
  output logic      o_busy,
  output logic      o_prot_hit
);
  typedef enum logic [2:0] {S_IDLE, S_CTRL, S_ADDR, S_WDATA, S_RDATA, S_RACK, S_IGNORE} eep_st_type;
  typedef struct packed {
    logic [1:0]  scl_s;
    logic [1:0]  sda_s;
    logic        scl_d;
    logic        sda_d;
    eep_st_type  st;
    logic [3:0]  bitn;
    logic [7:0]  sh;
    logic        rd;
    logic        ackph;
    logic [7:0]  ptr;
    logic [7:0]  wa;
    logic        wpend;
    logic [7:0]  wdat;
    logic [31:0] pcnt;
    logic        busy;
    logic        prot;
    logic        oe;
  } eep_dev_state_type;

  eep_dev_state_type s_r;
  eep_dev_state_type s_nxt;
  logic [7:0] mem [eep_pkg::MEM_DEPTH];
  logic       mem_we;
  logic       scl;
  logic       sda;
  logic       rise;
  logic       fall;
  logic       start;
  logic       stop;
  logic [7:0] rbyte;
  logic [63:0] id64;
  logic [47:0] id48;

  assign scl   = s_r.scl_s[1];
  assign sda   = s_r.sda_s[1];
  assign rise  = scl & ~s_r.scl_d;
  assign fall  = ~scl & s_r.scl_d;
  assign start = scl & s_r.scl_d & s_r.sda_d & ~sda;
  assign stop  = scl & s_r.scl_d & ~s_r.sda_d & sda;
  assign id48  = {ORG_ID, EXT_ID[23:0]};
  assign id64  = {ORG_ID, EXT_ID};

  // node id overlays top bytes; other upper bytes read as stored
  always_comb begin
    rbyte = mem[s_r.ptr];
    if (ID64 && s_r.ptr >= eep_pkg::NODE64_BASE) begin
      rbyte = id64[8'(8'd63 - 8'((s_r.ptr - eep_pkg::NODE64_BASE) * 8'd8)) -: 8];
    end else if (!ID64 && s_r.ptr >= eep_pkg::NODE48_BASE) begin
      rbyte = id48[8'(8'd47 - 8'((s_r.ptr - eep_pkg::NODE48_BASE) * 8'd8)) -: 8];
    end
  end

  always_comb begin
    s_nxt = s_r;
    mem_we = 1'b0;
    s_nxt.scl_s = {s_r.scl_s[0], bus.scl};
    s_nxt.sda_s = {s_r.sda_s[0], bus.sda};
    s_nxt.scl_d = scl;
    s_nxt.sda_d = sda;
    s_nxt.prot  = 1'b0;
    if (s_r.busy) begin
      if (s_r.pcnt == 32'(PROG_CYC - 1)) begin
        s_nxt.busy = 1'b0;
        s_nxt.pcnt = '0;
      end else begin
        s_nxt.pcnt = 32'(s_r.pcnt + 32'd1);
      end
    end
    if (start) begin
      s_nxt.st = S_CTRL;
      s_nxt.bitn = '0;
      s_nxt.ackph = 1'b0;
      s_nxt.oe = 1'b0;
      s_nxt.wpend = 1'b0;
    end else if (stop) begin
      s_nxt.st = S_IDLE;
      s_nxt.oe = 1'b0;
      if (s_r.wpend) begin
        s_nxt.wpend = 1'b0;
        if (s_r.wa >= eep_pkg::PROT_BASE) begin
          s_nxt.prot = 1'b1;
        end else if (!i_vdd_low) begin
          mem_we = 1'b1;
          s_nxt.busy = 1'b1;
          s_nxt.pcnt = '0;
        end
      end
    end else if (rise && !s_r.ackph && s_r.st != S_IDLE && s_r.st != S_IGNORE && s_r.st != S_RDATA) begin
      s_nxt.sh = {s_r.sh[6:0], sda};
      s_nxt.bitn = 4'(s_r.bitn + 4'd1);
    end else if (rise && s_r.ackph && s_r.st == S_RACK) begin
      if (sda) begin
        s_nxt.st = S_IGNORE;
      end else begin
        s_nxt.st = S_RDATA;
      end
    end else if (fall) begin
      s_nxt.oe = 1'b0;
      if (s_r.ackph) begin
        s_nxt.ackph = 1'b0;
        s_nxt.bitn = '0;
        if (s_r.st == S_RDATA) begin
          s_nxt.sh = rbyte;
          s_nxt.oe = ~rbyte[7];
          s_nxt.bitn = 4'd1;
        end
      end else if (s_r.st == S_RDATA && s_r.bitn < eep_pkg::BIT_LAST) begin
        s_nxt.oe = ~s_r.sh[7 - s_r.bitn[2:0]];
        s_nxt.bitn = 4'(s_r.bitn + 4'd1);
      end else if (s_r.bitn == eep_pkg::BIT_LAST) begin
        s_nxt.ackph = 1'b1;
        case (s_r.st)
          S_CTRL: begin
            if (s_r.sh[7:4] == eep_pkg::CTRL_CODE && !s_r.busy) begin
              s_nxt.oe = 1'b1;
              s_nxt.rd = s_r.sh[0];
              s_nxt.st = s_r.sh[0] ? S_RDATA : S_ADDR;
            end else begin
              s_nxt.st = S_IGNORE;
            end
          end
          S_ADDR: begin
            s_nxt.oe = 1'b1;
            s_nxt.ptr = s_r.sh;
            s_nxt.st = S_WDATA;
          end
          S_WDATA: begin
            s_nxt.oe = 1'b1;
            s_nxt.wa = s_r.ptr;
            s_nxt.wdat = s_r.sh;
            s_nxt.wpend = 1'b1;
            s_nxt.ptr = eep_pkg::eep_inc(s_r.ptr);
          end
          S_RDATA: begin
            s_nxt.st = S_RACK;
            s_nxt.ptr = eep_pkg::eep_inc(s_r.ptr);
          end
          default: s_nxt.st = S_IGNORE;
        endcase
      end
    end
    if (s_r.st == S_RACK) begin
      s_nxt.oe = 1'b0;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_r <= '{scl_s: 2'b11, sda_s: 2'b11, scl_d: 1'b1, sda_d: 1'b1, st: S_IDLE, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (mem_we) begin
      mem[s_r.wa] <= s_r.wdat;
    end
  end

  assign bus.sda_s_o  = 1'b0;
  assign bus.sda_s_oe = s_r.oe;
  assign o_busy       = s_r.busy;
  assign o_prot_hit   = s_r.prot;
endmodule
`default_nettype wire

// File: rtl/eep_host.sv
`timescale 1ns/10ps
`default_nettype none
module eep_host (
  input  wire logic       i_mclk,
  input  wire logic       i_rst_n,
  input  wire logic       i_req,
  input  wire logic [1:0] i_op,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic [7:0] i_len,
  eep_if.host             bus,
  output logic            o_ready,
  output logic            o_rvalid,
  output logic [7:0]      o_rdata,
  output logic            o_nack
);
  // op: 0 write byte, 1 current read, 2 random/sequential read, 3 poll
  typedef enum logic [2:0] {H_IDLE, H_START, H_BYTE, H_ACK, H_RBYTE, H_MACK, H_STOP} eep_hst_type;
  typedef struct packed {
    logic [1:0]  sda_s;
    eep_hst_type st;
    logic [7:0]  div;
    logic [1:0]  ph;
    logic [3:0]  bitn;
    logic [7:0]  sh;
    logic [2:0]  idx;
    logic [1:0]  op;
    logic [7:0]  addr;
    logic [7:0]  wdat;
    logic [7:0]  left;
    logic        scl;
    logic        oe;
    logic        rdy;
    logic        rv;
    logic [7:0]  rd;
    logic        nack;
  } eep_host_state_type;

  eep_host_state_type h_r;
  eep_host_state_type h_nxt;
  logic tick;
  logic sda;
  assign sda  = h_r.sda_s[1];
  assign tick = h_r.div == 8'(eep_pkg::SCL_HALF_CYC - 1);

  function automatic logic [7:0] ctl(input logic rd);
    return {eep_pkg::CTRL_CODE, 3'b000, rd};
  endfunction

  always_comb begin
    h_nxt = h_r;
    h_nxt.sda_s = {h_r.sda_s[0], bus.sda};
    h_nxt.rv = 1'b0;
    h_nxt.div = tick ? 8'h00 : 8'(h_r.div + 8'h01);
    if (h_r.st == H_IDLE) begin
      h_nxt.div = '0;
      h_nxt.rdy = 1'b1;
      if (i_req) begin
        h_nxt.rdy = 1'b0;
        h_nxt.op = i_op;
        h_nxt.addr = i_addr;
        h_nxt.wdat = i_wdata;
        h_nxt.left = i_len;
        h_nxt.idx = '0;
        h_nxt.nack = 1'b0;
        h_nxt.st = H_START;
        h_nxt.ph = '0;
      end
    end else if (tick) begin
      h_nxt.ph = 2'(h_r.ph + 2'd1);
      case (h_r.st)
        H_START: begin
          case (h_r.ph)
            2'd0: begin
              h_nxt.scl = 1'b1;
              h_nxt.oe = 1'b0;
            end
            2'd1: h_nxt.oe = 1'b1;
            2'd2: h_nxt.scl = 1'b0;
            default: begin
              // read bit only for the final control byte
              h_nxt.sh = ctl((h_r.op == 2'd1) || (h_r.op == 2'd2 && h_r.idx != 3'd0));
              h_nxt.bitn = '0;
              h_nxt.st = H_BYTE;
              h_nxt.ph = '0;
            end
          endcase
        end
        H_BYTE, H_RBYTE: begin
          case (h_r.ph)
            2'd0: h_nxt.oe = (h_r.st == H_BYTE) ? ~h_r.sh[7] : 1'b0;
            2'd1: h_nxt.scl = 1'b1;
            2'd2: begin
              h_nxt.scl = 1'b0;
              h_nxt.sh = {h_r.sh[6:0], sda};
              h_nxt.bitn = 4'(h_r.bitn + 4'd1);
            end
            default: begin
              h_nxt.ph = '0;
              if (h_r.bitn == eep_pkg::BIT_LAST) begin
                h_nxt.st = (h_r.st == H_BYTE) ? H_ACK : H_MACK;
              end
            end
          endcase
        end
        H_ACK: begin
          case (h_r.ph)
            2'd0: h_nxt.oe = 1'b0;
            2'd1: h_nxt.scl = 1'b1;
            2'd2: begin
              h_nxt.scl = 1'b0;
              h_nxt.nack = sda;
            end
            default: begin
              h_nxt.ph = '0;
              h_nxt.bitn = '0;
              h_nxt.idx = 3'(h_r.idx + 3'd1);
              if (h_r.nack || h_r.op == 2'd3) begin
                h_nxt.st = H_STOP;
              end else if (h_r.op != 2'd0 && (h_r.op == 2'd1 || h_r.idx == 3'd2)) begin
                h_nxt.st = H_RBYTE;
              end else if (h_r.op == 2'd2) begin
                h_nxt.sh = h_r.addr;
                h_nxt.st = (h_r.idx == 3'd1) ? H_START : H_BYTE;
                if (h_r.idx == 3'd0) h_nxt.st = H_BYTE;
              end else if (h_r.idx == 3'd0) begin
                h_nxt.sh = h_r.addr;
                h_nxt.st = H_BYTE;
              end else if (h_r.idx == 3'd1) begin
                h_nxt.sh = h_r.wdat;
                h_nxt.st = H_BYTE;
              end else begin
                h_nxt.st = H_STOP;
              end
            end
          endcase
        end
        H_MACK: begin
          case (h_r.ph)
            2'd0: begin
              h_nxt.rd = h_r.sh;
              h_nxt.rv = 1'b1;
              h_nxt.left = 8'(h_r.left - 8'h01);
              h_nxt.oe = (h_r.left > 8'h01);
            end
            2'd1: h_nxt.scl = 1'b1;
            2'd2: h_nxt.scl = 1'b0;
            default: begin
              h_nxt.ph = '0;
              h_nxt.bitn = '0;
              h_nxt.st = (h_r.left == 8'h00) ? H_STOP : H_RBYTE;
            end
          endcase
        end
        H_STOP: begin
          case (h_r.ph)
            2'd0: h_nxt.oe = 1'b1;
            2'd1: h_nxt.scl = 1'b1;
            2'd2: h_nxt.oe = 1'b0;
            default: begin
              h_nxt.st = H_IDLE;
              h_nxt.ph = '0;
            end
          endcase
        end
        default: h_nxt.st = H_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      h_r <= '{sda_s: 2'b11, st: H_IDLE, scl: 1'b1, default: '0};
    end else begin
      h_r <= h_nxt;
    end
  end

  assign bus.scl      = h_r.scl;
  assign bus.sda_m_o  = 1'b0;
  assign bus.sda_m_oe = h_r.oe;
  assign o_ready      = h_r.rdy;
  assign o_rvalid     = h_r.rv;
  assign o_rdata      = h_r.rd;
  assign o_nack       = h_r.nack;
endmodule
`default_nettype wire

// File: verif/eep_checker.sv
`timescale 1ns/10ps
`default_nettype none
module eep_checker #(
  parameter int unsigned PROG_CYC = 50
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_s_oe,
  input wire logic o_busy,
  input wire logic i_vdd_low
);
  logic        scl_r;
  logic        sda_r;
  logic        first_r;
  logic [3:0]  nbit_r;
  logic [7:0]  sh_r;
  logic [7:0]  ctl_r;
  logic [31:0] bcnt_r;
  wire rise = scl & ~scl_r;
  wire start = scl & scl_r & sda_r & ~sda;
  wire ack = rise & (nbit_r == 4'h8);
  wire is_ctl = ack & first_r & (sh_r[7:4] == eep_pkg::CTRL_CODE);
  wire is_wr = ack & ~first_r & ~ctl_r[0] & (ctl_r[7:4] == eep_pkg::CTRL_CODE);
  wire is_rd = ack & ~first_r & ctl_r[0];

  // bit counter restarts at every start, so a repeated start re-reads the control byte
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      scl_r <= 1'h1;
      sda_r <= 1'h1;
      first_r <= 1'h0;
      nbit_r <= 4'h0;
      sh_r <= 8'h00;
      ctl_r <= 8'h00;
      bcnt_r <= 32'h0000_0000;
    end else begin
      scl_r <= scl;
      sda_r <= sda;
      bcnt_r <= o_busy ? bcnt_r + 32'h0000_0001 : 32'h0000_0000;
      if (start) begin
        nbit_r <= 4'h0;
        first_r <= 1'h1;
      end else if (ack) begin
        nbit_r <= 4'h0;
        first_r <= 1'h0;
        if (first_r) ctl_r <= sh_r;
      end else if (rise) begin
        nbit_r <= nbit_r + 4'h1;
        sh_r <= {sh_r[6:0], sda};
      end
    end
  end

  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  a_busy_drive: assert property (o_busy |-> !sda_s_oe)
    else $error("device drives data while programming");
  a_busy_nack: assert property (ack && o_busy |-> sda)
    else $error("acknowledge given while programming");
  // ack is decided some 22 cycles before its clock; busy only rises at a stop
  a_ctl_ack: assert property (is_ctl && !$past(o_busy, 30) |-> !sda)
    else $error("control byte not acknowledged");
  a_word_ack: assert property (is_wr && !o_busy |-> !sda)
    else $error("write byte not acknowledged");
  a_read_slot: assert property (is_rd |-> !sda_s_oe)
    else $error("device drives the host acknowledge slot");
  a_nack_release: assert property (is_rd && sda |=> !sda_s_oe [*8])
    else $error("data line not released after host nack");
  a_oe_scl_low: assert property ($changed(sda_s_oe) |-> !scl)
    else $error("device data changed while clock high");
  a_prog_at_stop: assert property ($rose(o_busy) |-> scl && sda)
    else $error("programming started outside a stop");
  a_vdd_block: assert property (i_vdd_low |-> !$rose(o_busy))
    else $error("programming started at low supply");
  a_prog_span: assert property ($fell(o_busy) |-> bcnt_r >= PROG_CYC - 1 && bcnt_r <= PROG_CYC + 1)
    else $error("programming time wrong");

  c_ctl: cover property (is_ctl);
  c_prog: cover property ($rose(o_busy));
  c_rd_ack: cover property (is_rd && !sda);
  c_rd_nack: cover property (is_rd && sda);
endmodule
`default_nettype wire

// File: verif/i2c_eeprom_read_protect_nodeid_tb.sv
`timescale 1ns/10ps
`default_nettype none
module i2c_eeprom_read_protect_nodeid_tb;
  localparam int unsigned PROG = 1500;
  // id values are arbitrary
  localparam logic [23:0] ORG = 24'hAB_CDEF;
  localparam logic [39:0] EXT = 40'h12_3456_789A;
  typedef struct packed {
    logic [1:0]  op;
    logic [7:0]  a;
    logic [7:0]  d;
    logic [7:0]  n;
    logic [63:0] x;
  } eep_row_type;

  logic       i_mclk = 1'h0;
  logic       i_rst_n = 1'h0;
  logic       i_vdd_low = 1'h0;
  logic       i_req = 1'h0;
  logic [1:0] i_op = 2'h0;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic [7:0] i_len = 8'h01;
  logic       o_busy;
  logic       o_prot_hit;
  logic       o_ready;
  logic       o_rvalid;
  logic [7:0] o_rdata;
  logic       o_nack;
  int         errors = 0;
  int         n_checks = 0;
  int         prot_cnt = 0;
  logic [7:0] rq[$];
  logic [7:0] rq48[$];
  logic       o_rvalid48;
  logic [7:0] o_rdata48;
  logic [47:0] exp48;
  logic [47:0] exp64t;
  logic [63:0] enc64;
  eep_row_type rows [12] = '{
    '{2'h0, 8'h10, 8'hA5, 8'h00, 64'h0},
    '{2'h0, 8'h11, 8'h3C, 8'h00, 64'h0},
    '{2'h0, 8'h7F, 8'h96, 8'h00, 64'h0},
    '{2'h0, 8'h00, 8'h5A, 8'h00, 64'h0},
    '{2'h0, 8'h20, 8'h11, 8'h00, 64'h0},
    '{2'h0, 8'hFA, 8'h00, 8'h00, 64'h0},
    '{2'h2, 8'h10, 8'h00, 8'h02, {8'hA5, 8'h3C, 48'h0}},
    '{2'h2, 8'h7F, 8'h00, 8'h01, {8'h96, 56'h0}},
    '{2'h2, 8'h10, 8'h00, 8'h01, {8'hA5, 56'h0}},
    '{2'h1, 8'h00, 8'h00, 8'h01, {8'h3C, 56'h0}},
    '{2'h2, 8'hF8, 8'h00, 8'h08, {ORG, EXT}},
    '{2'h2, 8'hFF, 8'h00, 8'h02, {EXT[7:0], 8'h5A, 48'h0}}
  };

  eep_if u_eep_if();
  eep_dev #(.PROG_CYC(PROG), .ID64(1'b1), .ORG_ID(ORG), .EXT_ID(EXT)) u_eep_dev (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_vdd_low(i_vdd_low), .bus(u_eep_if.dev),
    .o_busy(o_busy), .o_prot_hit(o_prot_hit));
  eep_host u_eep_host (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_req(i_req), .i_op(i_op), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_len(i_len), .bus(u_eep_if.host), .o_ready(o_ready),
    .o_rvalid(o_rvalid), .o_rdata(o_rdata), .o_nack(o_nack));
  eep_checker #(.PROG_CYC(PROG)) u_eep_checker (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .scl(u_eep_if.scl), .sda(u_eep_if.sda),
    .sda_s_oe(u_eep_if.sda_s_oe), .o_busy(o_busy), .i_vdd_low(i_vdd_low));
  // 48-bit id variant, driven in lockstep with the same requests
  eep_if u_eep_if48();
  eep_dev #(.PROG_CYC(PROG), .ID64(1'b0), .ORG_ID(ORG), .EXT_ID(EXT)) u_eep_dev48 (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_vdd_low(i_vdd_low), .bus(u_eep_if48.dev),
    .o_busy(), .o_prot_hit());
  eep_host u_eep_host48 (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_req(i_req), .i_op(i_op), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_len(i_len), .bus(u_eep_if48.host), .o_ready(),
    .o_rvalid(o_rvalid48), .o_rdata(o_rdata48), .o_nack());

  initial begin
    forever #2 i_mclk = ~i_mclk;
  end

  always @(posedge i_mclk) begin
    if (o_prot_hit === 1'b1) prot_cnt++;
  end

  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic do_reset();
    i_rst_n = 1'b0;
    repeat (16) @(posedge i_mclk);
    chk("busy_in_reset", 32'(o_busy), 32'h0);
    chk("scl_in_reset", 32'(u_eep_if.scl), 32'h1);
    #1 i_rst_n = 1'b1;
  endtask

  // one host operation; read bytes are gathered in rq
  task automatic op(input logic [1:0] k, input logic [7:0] a, input logic [7:0] d, input logic [7:0] n);
    int t;
    t = 0;
    rq.delete();
    rq48.delete();
    while (o_ready !== 1'b1 && t < 9000) begin
      @(posedge i_mclk);
      #1 t++;
    end
    i_op = k;
    i_addr = a;
    i_wdata = d;
    i_len = n;
    i_req = 1'b1;
    @(posedge i_mclk);
    #1 i_req = 1'b0;
    while (o_ready === 1'b1 && t < 9000) begin
      @(posedge i_mclk);
      #1 t++;
    end
    while (o_ready !== 1'b1 && t < 9000) begin
      if (o_rvalid === 1'b1) rq.push_back(o_rdata);
      if (o_rvalid48 === 1'b1) rq48.push_back(o_rdata48);
      @(posedge i_mclk);
      #1 t++;
    end
    if (t >= 9000) begin
      errors++;
      complete_run();
    end
  endtask

  task automatic poll(input logic busy_exp);
    int k;
    int nk;
    nk = 0;
    for (k = 0; k < 40; k++) begin
      op(2'h3, 8'h00, 8'h00, 8'h01);
      if (o_nack !== 1'b1) break;
      nk++;
    end
    chk("poll_done", 32'(k < 40), 32'h1);
    if (busy_exp) chk("poll_busy", 32'(nk > 0), 32'h1);
  endtask

  initial begin
    do_reset();
    foreach (rows[r]) begin
      op(rows[r].op, rows[r].a, rows[r].d, rows[r].n);
      chk("byte_count", 32'(rq.size()), 32'(rows[r].n));
      for (int i = 0; i < rows[r].n; i++) begin
        chk("rdata", 32'(rq[i]), 32'(rows[r].x[63-8*i -: 8]));
      end
      if (rows[r].op == 2'h0) poll(rows[r].a < eep_pkg::PROT_BASE);
      $display("row %0d done", r);
    end
    // top six bytes on both id variants, then host side encapsulation
    op(2'h2, eep_pkg::NODE48_BASE, 8'h00, 8'h06);
    exp48 = {ORG, EXT[23:0]};
    exp64t = {ORG[7:0], EXT};
    for (int i = 0; i < 6; i++) begin
      chk("id48", 32'(rq48[i]), 32'(exp48[47-8*i -: 8]));
      chk("id64_top", 32'(rq[i]), 32'(exp64t[47-8*i -: 8]));
    end
    chk("ext_rsvd", 32'({rq[1], rq[2]} == eep_pkg::ENCAP_FILL || {rq[1], rq[2]} == eep_pkg::RSVD_EXT),
        32'h0);
    enc64 = {rq48[0], rq48[1], rq48[2], eep_pkg::ENCAP_FILL, rq48[3], rq48[4], rq48[5]};
    chk("encap_hi", enc64[63:32], {ORG, eep_pkg::ENCAP_FILL[15:8]});
    chk("encap_lo", enc64[31:0], {eep_pkg::ENCAP_FILL[7:0], EXT[23:0]});
    $display("node id case done");
    // low supply must drop the write without a busy phase
    i_vdd_low = 1'b1;
    op(2'h0, 8'h20, 8'h77, 8'h01);
    poll(1'b0);
    i_vdd_low = 1'b0;
    op(2'h2, 8'h20, 8'h00, 8'h01);
    chk("vdd_keep", 32'(rq[0]), 32'h11);
    chk("prot_pulse", 32'(prot_cnt), 32'h1);
    $display("low supply case done");
    // reset while programming runs
    op(2'h0, 8'h30, 8'h44, 8'h01);
    do_reset();
    op(2'h2, 8'h10, 8'h00, 8'h01);
    chk("after_reset", 32'(rq[0]), 32'hA5);
    $display("mid run reset case done");
    complete_run();
  end
endmodule
`default_nettype wire
